// File: rtl/tlc_pkg.sv
// Purpose: constants for the token lan command decoder
// Assumes: axi4-lite register access, 32-bit data
// Notes:   command encodings, register offsets, flag positions
`default_nettype none
package tlc_pkg;
  // register byte offsets
  localparam logic [3:0] TLC_OFF_CMD    = 4'h0;
  localparam logic [3:0] TLC_OFF_STATUS = 4'h4;
  localparam logic [3:0] TLC_OFF_MASK   = 4'h8;
  localparam logic [3:0] TLC_OFF_CTRL   = 4'hc;
  // status flag positions
  localparam int TLC_B_RXH  = 7;
  localparam int TLC_B_POR  = 4;
  localparam int TLC_B_RCF  = 2;
  localparam int TLC_B_ACK  = 1;
  localparam int TLC_B_TXF  = 0;
  localparam logic [7:0] TLC_FLAG_MASK = 8'h97;
  // reset value: power-on set, transmitter free
  localparam logic [7:0] TLC_STATUS_RST = 8'h11;
  // command encodings
  localparam logic [7:0] TLC_CMD_CLR_TXI = 8'h00;
  localparam logic [7:0] TLC_CMD_DIS_TX  = 8'h01;
  localparam logic [7:0] TLC_CMD_DIS_RX  = 8'h02;
  localparam logic [7:0] TLC_CMD_CLR_RXI = 8'h08;
  localparam logic [2:0] TLC_OP_TX   = 3'h3;
  localparam logic [2:0] TLC_OP_RX   = 3'h4;
  localparam logic [2:0] TLC_OP_CFG  = 3'h5;
  localparam logic [2:0] TLC_OP_CLR  = 3'h6;
  localparam int TLC_B_BCAST = 7;
  localparam int TLC_B_LONG  = 3;
  localparam int TLC_B_CLRP  = 3;
  localparam int TLC_B_CLRR  = 4;
  localparam int TLC_B_CHAIN = 0;
  localparam logic [7:0] TLC_BCAST_ID = 8'h00;
  localparam logic [1:0] TLC_RESP_OK    = 2'h0;
  localparam logic [1:0] TLC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TLC_TX_IDLE = 2'b00,
    TLC_TX_ARMED = 2'b01,
    TLC_TX_BUSY = 2'b10
  } tlc_tx_e;
endpackage
`default_nettype wire

// File: rtl/tlc_cmd_decoder.sv
// Purpose: command decoder and status flags of a token lan controller
// Assumes: link engine reports token, tx done/ack, rx start/done on aclk
// Notes:   registers over axi4-lite; one level interrupt from status & mask
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`default_nettype none
// Behaviour
// R1 - chaining clear codes only act in chaining mode
// R2 - disable transmitter cancels unstarted transmit
// R3 - disable transmitter: free flag at next token
// R4 - disable receiver cancels pending receive
// R5 - idle receiver disabled: halted at next token
// R6 - reception under way finishes normally
// R7 - arm transmit from page bits 4:3
// R8 - transmit command clears free and acked
// R9 - transmit completion sets free flag
// R10 - acked only on hardware ack, before free
// R11 - enable receive to page, clear halted
// R12 - bit 7 accepts broadcast packets
// R13 - destination zero is broadcast
// R14 - good reception sets halted flag
// R15 - bit c selects long or short packets
// R16 - clear flags: p power-on, r reconfig
// R17 - status bit layout, masked interrupts
// R18 - halted receiver accepts no packets
// R19 - undefined codes ignored
module tlc_cmd_decoder
  import tlc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link engine events
  input  wire logic        token_seen,
  input  wire logic        tx_started,
  input  wire logic        tx_done,
  input  wire logic        tx_acked,
  input  wire logic        rx_started,
  input  wire logic [7:0]  rx_dest_id,
  input  wire logic        rx_done_ok,
  input  wire logic        rx_aborted,
  input  wire logic        power_on_event,
  input  wire logic        reconfig_event,
  // link engine controls
  output var  logic        tx_go,
  output var  logic [1:0]  tx_page,
  output var  logic        rx_enable,
  output var  logic [1:0]  rx_page,
  output var  logic        rx_accept,
  output var  logic        long_packets,
  output var  logic        chain_clr_tx,
  output var  logic        chain_clr_rx,
  // interrupt
  output var  logic        irq
);

  logic [7:0] status;
  logic [7:0] mask;
  logic       chain_en;
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  tlc_tx_e    tx_state;
  logic       rx_armed;
  logic       rx_active;
  logic       rx_bcast;
  logic       txf_pend;
  logic       rxh_pend;

  // write path: address and data taken in either order
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_cmd   = do_write && (aw_addr == TLC_OFF_CMD) && w_strb[0];
  wire [7:0] cmd = w_data[7:0];
  wire [7:0] status_w1c = (do_write && aw_addr == TLC_OFF_STATUS && w_strb[0]) ? w_data[7:0] : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TLC_RESP_OK;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[1:0] != 2'b00) ? TLC_RESP_SLVERR : TLC_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // mask and control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask     <= 8'h00;
      chain_en <= 1'b0;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == TLC_OFF_MASK)
        mask <= w_data[7:0] & TLC_FLAG_MASK; // R17
      if (aw_addr == TLC_OFF_CTRL)
        chain_en <= w_data[TLC_B_CHAIN];
    end
  end

  // command decode strobes
  wire c_dis_tx = wr_cmd && cmd == TLC_CMD_DIS_TX;
  wire c_dis_rx = wr_cmd && cmd == TLC_CMD_DIS_RX;
  wire c_tx     = wr_cmd && cmd[7:5] == 3'h0 && cmd[2:0] == TLC_OP_TX; // R7
  wire c_rx     = wr_cmd && cmd[6:5] == 2'h0 && cmd[2:0] == TLC_OP_RX; // R11
  wire c_cfg    = wr_cmd && cmd[7:4] == 4'h0 && cmd[2:0] == TLC_OP_CFG; // R15
  wire c_clr    = wr_cmd && cmd[7:5] == 3'h0 && cmd[2:0] == TLC_OP_CLR; // R16
  // other codes fall through with no effect
  wire c_ctxi   = wr_cmd && cmd == TLC_CMD_CLR_TXI && chain_en; // R1 R19
  wire c_crxi   = wr_cmd && cmd == TLC_CMD_CLR_RXI && chain_en; // R1 R19

  // chaining clear strobes passed to the chaining logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_clr_tx <= 1'b0;
      chain_clr_rx <= 1'b0;
    end else begin
      chain_clr_tx <= c_ctxi; // R1
      chain_clr_rx <= c_crxi; // R1
    end
  end

  // transmit scheduling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= TLC_TX_IDLE;
      tx_page  <= 2'h0;
      tx_go    <= 1'b0;
      txf_pend <= 1'b0;
    end else begin
      tx_go <= 1'b0;
      case (tx_state)
        TLC_TX_IDLE: begin
          if (c_tx) begin
            tx_state <= TLC_TX_ARMED; // R7
            tx_page  <= cmd[4:3];
          end
        end
        TLC_TX_ARMED: begin
          if (c_dis_tx) begin
            tx_state <= TLC_TX_IDLE; // R2
          end else begin
            // a rewrite only swaps the page, never delays the start
            if (c_tx)
              tx_page <= cmd[4:3];
            if (token_seen) begin
              tx_go    <= 1'b1; // R7
              tx_state <= TLC_TX_BUSY;
            end
          end
        end
        TLC_TX_BUSY: begin
          // a started frame is not cancelled
          if (tx_done)
            tx_state <= TLC_TX_IDLE;
        end
        default: tx_state <= TLC_TX_IDLE;
      endcase
      if (c_dis_tx)
        txf_pend <= 1'b1; // R3
      else if (c_tx || token_seen)
        txf_pend <= 1'b0;
    end
  end

  // id is judged as it arrives with the start pulse, not before
  wire dest_ok = (rx_dest_id != TLC_BCAST_ID) || rx_bcast; // R13 R12

  // receive scheduling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_armed  <= 1'b0;
      rx_active <= 1'b0;
      rx_page   <= 2'h0;
      rx_bcast  <= 1'b0;
      rxh_pend  <= 1'b0;
    end else begin
      if (c_rx) begin
        rx_armed <= 1'b1; // R11
        rx_page  <= cmd[4:3];
        rx_bcast <= cmd[TLC_B_BCAST]; // R12
        rxh_pend <= 1'b0;
      end else if (c_dis_rx) begin
        rx_armed <= 1'b0; // R4
        rxh_pend <= !rx_active && !status[TLC_B_RXH]; // R5 R6
      end else if (token_seen) begin
        rxh_pend <= 1'b0;
      end
      if (rx_started && rx_accept && dest_ok)
        rx_active <= 1'b1; // R13
      else if (rx_done_ok || rx_aborted)
        rx_active <= 1'b0; // R6
    end
  end

  // halted receiver takes nothing

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_enable    <= 1'b0;
      rx_accept    <= 1'b0;
      long_packets <= 1'b0;
    end else begin
      rx_enable <= (rx_armed || c_rx) && !(c_dis_rx && !c_rx);
      rx_accept <= rx_armed && !status[TLC_B_RXH]; // R18
      if (c_cfg)
        long_packets <= cmd[TLC_B_LONG]; // R15
    end
  end

  // status flags; a hardware set wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= TLC_STATUS_RST;
    end else begin
      status <= status & ~status_w1c;
      if (c_tx) begin
        status[TLC_B_TXF] <= 1'b0; // R8
        status[TLC_B_ACK] <= 1'b0; // R8
      end
      if (tx_state == TLC_TX_BUSY && tx_acked)
        status[TLC_B_ACK] <= 1'b1; // R10
      if (tx_state == TLC_TX_BUSY && tx_done)
        status[TLC_B_TXF] <= 1'b1; // R9
      if (txf_pend && token_seen)
        status[TLC_B_TXF] <= 1'b1; // R3
      if (c_rx)
        status[TLC_B_RXH] <= 1'b0; // R11
      if (rx_active && rx_done_ok)
        status[TLC_B_RXH] <= 1'b1; // R14
      if (rxh_pend && token_seen)
        status[TLC_B_RXH] <= 1'b1; // R5
      if (c_clr && cmd[TLC_B_CLRP])
        status[TLC_B_POR] <= 1'b0; // R16
      if (c_clr && cmd[TLC_B_CLRR])
        status[TLC_B_RCF] <= 1'b0; // R16
      if (power_on_event)
        status[TLC_B_POR] <= 1'b1;
      if (reconfig_event)
        status[TLC_B_RCF] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status & mask); // R17
  end

  // read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TLC_RESP_OK;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= TLC_RESP_OK;
        case (s_axi_araddr)
          TLC_OFF_CMD:    s_axi_rdata <= 32'h0000_0000;
          TLC_OFF_STATUS: s_axi_rdata <= {24'h00_0000, status};
          TLC_OFF_MASK:   s_axi_rdata <= {24'h00_0000, mask};
          TLC_OFF_CTRL:   s_axi_rdata <= {29'h0000_0000, long_packets, 1'b0, chain_en};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TLC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  sequence s_halt_then_closed;
    status[TLC_B_RXH] ##1 !rx_accept;
  endsequence

  AST_TX_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    c_tx && !(txf_pend && token_seen) |=> !status[TLC_B_TXF] && !status[TLC_B_ACK])
    else $error("transmit command did not clear flags");
  AST_DISTX_CANCEL: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    c_dis_tx && tx_state == TLC_TX_ARMED |=> tx_state == TLC_TX_IDLE)
    else $error("armed transmit not cancelled");
  AST_DISTX_TOKEN: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    txf_pend && token_seen |=> status[TLC_B_TXF])
    else $error("free flag not set at token");
  AST_TX_GO: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    tx_state == TLC_TX_ARMED && token_seen && !c_dis_tx |=> tx_go && tx_state == TLC_TX_BUSY)
    else $error("armed transmit not started");
  AST_TX_DONE: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    tx_state == TLC_TX_BUSY && tx_done |=> status[TLC_B_TXF])
    else $error("completion did not free transmitter");
  AST_ACK_ONLY: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    $rose(status[TLC_B_ACK]) |-> $past(tx_acked) && $past(tx_state) == TLC_TX_BUSY)
    else $error("acked flag set without acknowledge");
  AST_RX_EN: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    c_rx |=> rx_armed && rx_page == $past(cmd[4:3]) && rx_bcast == $past(cmd[TLC_B_BCAST]))
    else $error("enable receive not taken");
  AST_RX_HALT: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    rx_active && rx_done_ok |=> s_halt_then_closed)
    else $error("halted flag not set after reception");
  AST_HALT_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    status[TLC_B_RXH] |=> !rx_accept)
    else $error("halted receiver still accepting");
  AST_CLR_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    c_clr && cmd[TLC_B_CLRP] && !power_on_event |=> !status[TLC_B_POR])
    else $error("power-on flag not cleared");
  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    |(status & mask) |=> irq)
    else $error("interrupt missing");
  AST_IRQ_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    !(|(status & mask)) |=> !irq)
    else $error("interrupt without unmasked flag");
  AST_DISRX_CANCEL: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    c_dis_rx |=> !rx_armed)
    else $error("pending receive not cancelled");
  AST_DISRX_TOKEN: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    rxh_pend && token_seen |=> status[TLC_B_RXH])
    else $error("halted flag not set at token");
  AST_BCAST_DROP: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    rx_started && rx_dest_id == TLC_BCAST_ID && !rx_bcast && !rx_active |=> !rx_active)
    else $error("broadcast taken while not enabled");
  AST_CFG: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    c_cfg |=> long_packets == $past(cmd[TLC_B_LONG]))
    else $error("packet length selection not taken");
  AST_CHAIN_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    wr_cmd && !chain_en |=> !chain_clr_tx && !chain_clr_rx)
    else $error("chaining clear outside chaining mode");

endmodule
`default_nettype wire

// File: testbench/tlc_link_model.sv
// Purpose: link engine stand-in facing the command decoder
// Assumes: one aclk domain, every event a one-cycle pulse
// Notes:   transmit takes 4 cycles after tx_go, a packet 8 cycles
`default_nettype none
module tlc_link_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench requests
  input  wire logic       tok_req,
  input  wire logic       pkt_req,
  input  wire logic [7:0] pkt_dest,
  input  wire logic       ack_on,
  // decoder controls
  input  wire logic       tx_go,
  input  wire logic       rx_accept,
  // events to decoder
  output logic            token_seen,
  output logic            tx_started,
  output logic            tx_done,
  output logic            tx_acked,
  output logic            rx_started,
  output logic [7:0]      rx_dest_id,
  output logic            rx_done_ok,
  output logic            rx_aborted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tcnt;
  logic [3:0] rcnt;
  logic       take;
  assign take       = pkt_req & rx_accept;
  assign rx_aborted = 1'b0;
  always_ff @(posedge aclk) begin
    token_seen <= tok_req;
    tx_started <= tx_go;
    tx_acked   <= (tcnt == 4'h2) & ack_on;
    tx_done    <= (tcnt == 4'h1);
    rx_started <= take;
    rx_done_ok <= (rcnt == 4'h1);
    // id is only valid with the start pulse, so it wanders otherwise
    rx_dest_id <= take ? pkt_dest : ~rx_dest_id;
    if (!aresetn) begin
      tcnt       <= 4'h0;
      rcnt       <= 4'h0;
      rx_dest_id <= 8'h00;
    end else begin
      tcnt <= tx_go ? 4'h4 : tcnt - 4'(tcnt != 4'h0);
      rcnt <= take ? 4'h8 : rcnt - 4'(rcnt != 4'h0);
    end
  end
endmodule
`default_nettype wire

// File: testbench/token_lan_command_decoder_tb.sv
// Purpose: self-checking bench for the command decoder
// Assumes: axi4-lite master tasks, link model on the far side
// Notes:   random pages and undefined codes from a fixed seed
`default_nettype none
module token_lan_command_decoder_tb import tlc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, power_on_event = 0, reconfig_event = 0;
  logic tok_req = 0, pkt_req = 0, ack_on = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [7:0] pkt_dest = 0, rx_dest_id, s0, c;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br, tx_page, rx_page, go_page, nn;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic token_seen, tx_started, tx_done, tx_acked, rx_started, rx_done_ok, rx_aborted;
  logic tx_go, rx_enable, rx_accept, long_packets, chain_clr_tx, chain_clr_rx, irq;
  int err_total = 0, n_checks = 0, n_go = 0, n_ctx = 0, n_crx = 0, cyc = 0, ego = 0;
  tlc_cmd_decoder i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .token_seen(token_seen), .tx_started(tx_started), .tx_done(tx_done), .tx_acked(tx_acked),
    .rx_started(rx_started), .rx_dest_id(rx_dest_id), .rx_done_ok(rx_done_ok), .rx_aborted(rx_aborted),
    .power_on_event(power_on_event), .reconfig_event(reconfig_event),
    .tx_go(tx_go), .tx_page(tx_page), .rx_enable(rx_enable), .rx_page(rx_page), .rx_accept(rx_accept),
    .long_packets(long_packets), .chain_clr_tx(chain_clr_tx), .chain_clr_rx(chain_clr_rx), .irq(irq)
  );
  tlc_link_model i_link (
    .aclk(aclk), .aresetn(aresetn), .tok_req(tok_req), .pkt_req(pkt_req), .pkt_dest(pkt_dest),
    .ack_on(ack_on), .tx_go(tx_go), .rx_accept(rx_accept), .token_seen(token_seen),
    .tx_started(tx_started), .tx_done(tx_done), .tx_acked(tx_acked), .rx_started(rx_started),
    .rx_dest_id(rx_dest_id), .rx_done_ok(rx_done_ok), .rx_aborted(rx_aborted)
  );
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tx_go === 1'b1) begin
      n_go    <= n_go + 1;
      go_page <= tx_page;
    end
    if (chain_clr_tx === 1'b1) n_ctx <= n_ctx + 1;
    if (chain_clr_rx === 1'b1) n_crx <= n_crx + 1;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  function automatic logic [7:0] f_tx(input logic [1:0] p);
    return {3'b000, p, 3'b011};
  endfunction
  function automatic logic [7:0] f_rx(input logic b, input logic [1:0] p);
    return {b, 2'b00, p, 3'b100};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] k);
    wr(TLC_OFF_CMD, {24'h0, k});
  endtask
  task automatic st(input string nm, input logic [7:0] m, input logic [7:0] e);
    rdr(TLC_OFF_STATUS);
    chk(nm, rd & {24'h0, m}, {24'h0, e});
  endtask
  task automatic tok;
    @(posedge aclk);
    tok_req <= 1'b1;
    @(posedge aclk);
    tok_req <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask
  task automatic pkt(input logic [7:0] d);
    @(posedge aclk);
    pkt_dest <= d;
    pkt_req  <= 1'b1;
    @(posedge aclk);
    pkt_req  <= 1'b0;
  endtask
  initial begin
    void'($urandom(70438));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    st("st_rst", 8'hff, TLC_STATUS_RST);
    rdr(TLC_OFF_MASK);
    chk("mask_rst", rd, 32'h0);
    rdr(4'h2);
    chk("misaligned", {30'h0, rr}, {30'h0, TLC_RESP_SLVERR});
    wr(4'h6, 32'h0);
    chk("wr_misaligned", {30'h0, br}, {30'h0, TLC_RESP_SLVERR});
    for (int i = 0; i < 4; i++) begin
      nn = 2'($urandom % 4);
      ack_on <= i[0];
      cmd(f_tx(nn));
      st("tx_armed", 8'h03, 8'h00);
      chk("go_early", n_go, ego);
      tok();
      ego++;
      chk("go", n_go, ego);
      chk("go_page", go_page, nn);
      st("tx_end", 8'h03, {6'h0, i[0], 1'b1});
    end
    cmd(f_tx(2'h1));
    cmd(TLC_CMD_DIS_TX);
    st("txf_wait", 8'h01, 8'h00);
    tok();
    chk("go_cancel", n_go, ego);
    st("txf_tok", 8'h01, 8'h01);
    cmd(f_rx(1'b0, 2'h2));
    st("rxh_clr", 8'h80, 8'h00);
    chk("rx_page", rx_page, 2'h2);
    chk("rx_en", rx_enable, 1'b1);
    pkt(8'h00);
    repeat (12) @(posedge aclk);
    st("no_bcast", 8'h80, 8'h00);
    pkt(8'h05);
    repeat (12) @(posedge aclk);
    st("rx_ok", 8'h80, 8'h80);
    chk("halted_acc", rx_accept, 1'b0);
    cmd(f_rx(1'b1, 2'h1));
    st("rxh_clr2", 8'h80, 8'h00);
    pkt(8'h00);
    repeat (12) @(posedge aclk);
    st("bcast", 8'h80, 8'h80);
    cmd(f_rx(1'b0, 2'h3));
    cmd(TLC_CMD_DIS_RX);
    st("dis_wait", 8'h80, 8'h00);
    chk("rx_off", rx_accept, 1'b0);
    chk("rx_en_off", rx_enable, 1'b0);
    tok();
    st("dis_tok", 8'h80, 8'h80);
    cmd(f_rx(1'b0, 2'h0));
    pkt(8'h07);
    cmd(TLC_CMD_DIS_RX);
    repeat (12) @(posedge aclk);
    st("rx_finish", 8'h80, 8'h80);
    cmd(8'h0d);
    chk("long", long_packets, 1'b1);
    cmd(8'h05);
    chk("short", long_packets, 1'b0);
    @(posedge aclk);
    reconfig_event <= 1'b1;
    @(posedge aclk);
    reconfig_event <= 1'b0;
    st("flags", 8'h14, 8'h14);
    cmd(8'h0e);
    st("clr_p", 8'h14, 8'h04);
    cmd(8'h16);
    st("clr_r", 8'h14, 8'h00);
    rdr(TLC_OFF_STATUS);
    s0 = rd[7:0];
    for (int i = 0; i < 6; i++) begin
      c = (i < 2) ? (i == 0 ? TLC_CMD_CLR_TXI : TLC_CMD_CLR_RXI) : {5'($urandom), 3'b111};
      cmd(c);
      st("undef", 8'hff, s0);
    end
    chk("chain_off", n_ctx + n_crx, 0);
    // chaining codes only once the mode is on
    wr(TLC_OFF_CTRL, 32'h1);
    cmd(TLC_CMD_CLR_TXI);
    cmd(TLC_CMD_CLR_RXI);
    @(posedge aclk);
    chk("chain_tx", n_ctx, 1);
    chk("chain_rx", n_crx, 1);
    wr(TLC_OFF_MASK, 32'h01);
    repeat (2) @(posedge aclk);
    chk("irq_on", irq, 1'b1);
    wr(TLC_OFF_STATUS, 32'h01);
    repeat (2) @(posedge aclk);
    chk("irq_clr", irq, 1'b0);
    @(posedge aclk);
    power_on_event <= 1'b1;
    @(posedge aclk);
    power_on_event <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("irq_masked", irq, 1'b0);
    wr(TLC_OFF_MASK, 32'h10);
    repeat (2) @(posedge aclk);
    chk("irq_por", irq, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
